/* design/crc_map.svh */
// constants of the range checksum engine and its host controller
// ==========================================================
`ifndef CRC_MAP_SVH
`define CRC_MAP_SVH
// opcodes
`define OP_START 8'h5b
`define OP_SUSP 8'h75
`define OP_RESUME 8'h7a
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h07
`define OP_READ_ANY_REGISTER_CMD 8'h65
`define OP_WREN 8'h06
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
// frame lengths in link bits and the bit counter ceiling
`define BITS_OP 6'd8
`define BITS_READ_ANY_REGISTER_CMD 6'd32
`define BITS_START 6'd56
`define BITS_MAX 6'h3f
// register read address of the result register
`define RESULT_RADDR 24'h000100
// status bit positions
`define SR1_WIP 0
`define SR1_WEL 1
`define SR2_ABORT 3
`define SR2_SUSP 4
// crc
`define CRC_POLY 32'h1edc6f41
`define CRC_INIT 32'h00000000
`define MIN_SPAN 24'h000003
// suspend processing time
`define CLK_MHZ 250
`define SUSP_NS 200
`define SUSP_CYC ((`SUSP_NS * `CLK_MHZ + 999) / 1000)
// host register offsets
`define H_CTRL 8'h00
`define H_ADDR0 8'h04
`define H_ADDR1 8'h08
`define H_STAT 8'h0c
`define H_RX 8'h10
// host control fields and link clock half period
`define CTRL_OP 7:0
`define CTRL_NADDR 10:8
`define CTRL_NRX 14:12
`define SCK_HALF 4
`endif

/* design/crc_pkg.sv */
// types of the range checksum engine and its host controller
package crc_pkg;
   typedef enum logic [1:0] {EN_IDLE, EN_READ, EN_TAKE, EN_SUSP} crc_eng_t;
   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END} crc_hst_t;
endpackage

/* design/crc_link_if.sv */
// single spi link between host controller and checksum device
`timescale 1ns/1ps
interface crc_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev (input sck, input cs_n, input mosi, output miso);
   modport host (output sck, output cs_n, output mosi, input miso);
endinterface

/* design/crc_step.sv */
// one 32-bit word step of the crc-32c shift register
`timescale 1ns/1ps
`include "crc_map.svh"
module crc_step (
   input wire logic [31:0] crc_in,
   input wire logic [31:0] word,
   output logic [31:0] crc_out
);
   import crc_pkg::*;
   // msb-first bitwise division, word bit 31 enters first
   always_comb begin
      logic [31:0] c;
      c = crc_in;
      for (int i = 31; i >= 0; i--) begin
         if (c[31] ^ word[i]) begin
            c = {c[30:0], 1'b0} ^ `CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      crc_out = c;
   end
endmodule

/* design/crc_dev.sv */
// checksum device end: spi command decode, status flags and crc engine
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "crc_map.svh"
module crc_dev #(
   parameter int AW = 18,
   parameter int SUSP_CYCLES = `SUSP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   crc_link_if.dev link,
   output logic mem_rd,
   output logic [AW-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic [31:0] result
);
   import crc_pkg::*;

   typedef struct packed {
      logic [1:0] sck_s;
      logic [1:0] cs_s;
      logic [1:0] mosi_s;
      logic sck_p;
      logic cs_p;
      logic [5:0] bits;
      logic [47:0] sh;
      logic [7:0] op;
      logic [31:0] tx;
      logic miso;
      logic rst_en;
      logic write_latch_flag;
      logic abort;
      logic susp;
      logic pend;
      logic [15:0] pcnt;
      crc_eng_t eng;
      logic [23:0] ea;
      logic [23:0] addr;
      logic [31:0] grp;
      logic [1:0] k;
      logic [31:0] crc;
   } crc_dev_t;

   crc_dev_t s_q, s_d;
   logic [31:0] word_in, crc_nx;
   logic sck_r, sck_f, cs_r, cs_f, running, allowed;
   logic [47:0] sh_n;
   logic [5:0] bits_n;
   logic [7:0] sr1, sr2;

   // word step for the current group, padded with zero bytes
   crc_step u_step (
      .crc_in(s_q.crc),
      .word(word_in),
      .crc_out(crc_nx)
   );

   // =======================================================
   // link edges and status bytes
   assign sck_r = s_q.sck_s[1] & ~s_q.sck_p;
   assign sck_f = ~s_q.sck_s[1] & s_q.sck_p;
   assign cs_r = s_q.cs_s[1] & ~s_q.cs_p;
   assign cs_f = ~s_q.cs_s[1] & s_q.cs_p;
   assign sh_n = {s_q.sh[46:0], s_q.mosi_s[1]};
   assign bits_n = (s_q.bits == `BITS_MAX) ? s_q.bits : s_q.bits + 6'd1;
   assign running = (s_q.eng == EN_READ) || (s_q.eng == EN_TAKE);
   // work flag covers the run and any suspend still being processed
   assign busy = running | s_q.pend;
   assign sr1 = {6'h00, s_q.write_latch_flag, busy};
   assign sr2 = {3'h0, s_q.susp, s_q.abort, 3'h0};
   assign word_in = s_q.grp | ({24'h000000, mem_rdata} << (5'd24 - {s_q.k, 3'b000}));
   assign mem_rd = (s_q.eng == EN_READ);
   assign mem_addr = s_q.addr[AW-1:0];
   assign link.miso = s_q.miso;
   assign result = s_q.crc;

   // command gate while a run is active or suspended
   always_comb begin
      if (running || s_q.pend) begin
         allowed = (s_q.op == `OP_RDSR1) || (s_q.op == `OP_RDSR2) ||
                   (s_q.op == `OP_SUSP);
      end else if (s_q.susp) begin
         allowed = (s_q.op == `OP_RDSR1) || (s_q.op == `OP_RDSR2) ||
                   (s_q.op == `OP_READ_ANY_REGISTER_CMD) || (s_q.op == `OP_RESUME) ||
                   (s_q.op == `OP_RSTEN) || (s_q.op == `OP_RST);
      end else begin
         allowed = 1'b1;
      end
   end

   // =======================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.sck_s = {s_q.sck_s[0], link.sck};
      s_d.cs_s = {s_q.cs_s[0], link.cs_n};
      s_d.mosi_s = {s_q.mosi_s[0], link.mosi};
      s_d.sck_p = s_q.sck_s[1];
      s_d.cs_p = s_q.cs_s[1];
      // receive: sample on rising link edge while selected
      if (cs_f) begin
         s_d.bits = 6'd0;
         s_d.tx = 32'h00000000;
      end else if (sck_r && !s_q.cs_s[1]) begin
         s_d.sh = sh_n;
         s_d.bits = bits_n;
         if (bits_n == `BITS_OP) begin
            s_d.op = sh_n[7:0];
            if (sh_n[7:0] == `OP_RDSR1) begin
               s_d.tx = {sr1, 24'h000000};
            end else if (sh_n[7:0] == `OP_RDSR2) begin
               s_d.tx = {sr2, 24'h000000};
            end
         end
         if (bits_n == `BITS_READ_ANY_REGISTER_CMD && s_q.op == `OP_READ_ANY_REGISTER_CMD && allowed) begin
            s_d.tx = (sh_n[23:0] == `RESULT_RADDR) ? s_q.crc : 32'h00000000;
         end
      end
      // transmit: next bit on falling link edge
      if (sck_f && !s_q.cs_s[1]) begin
         s_d.miso = s_q.tx[31];
         s_d.tx = {s_q.tx[30:0], 1'b0};
      end
      // act on frame end
      if (cs_r) begin
         s_d.rst_en = 1'b0;
         s_d.miso = 1'b0; // deselected data line rests low, no stale bit
         if (allowed) begin
            case (s_q.op)
               `OP_START: begin
                  if (s_q.bits == `BITS_START) begin
                     s_d.crc = `CRC_INIT;
                     s_d.susp = 1'b0;
                     if (s_q.sh[23:0] < s_q.sh[47:24] + `MIN_SPAN) begin
                        s_d.abort = 1'b1;
                     end else begin
                        s_d.abort = 1'b0;
                        s_d.addr = s_q.sh[47:24];
                        s_d.ea = s_q.sh[23:0];
                        s_d.grp = 32'h00000000;
                        s_d.k = 2'd0;
                        s_d.eng = EN_READ;
                     end
                  end
               end
               `OP_SUSP: begin
                  if (s_q.bits == `BITS_OP && running && !s_q.pend) begin
                     s_d.pend = 1'b1;
                     s_d.pcnt = 16'(SUSP_CYCLES);
                  end
               end
               `OP_RESUME: begin
                  if (s_q.bits == `BITS_OP && s_q.susp) begin
                     s_d.susp = 1'b0;
                     s_d.eng = EN_READ;
                  end
               end
               `OP_WREN: begin
                  if (s_q.bits == `BITS_OP) begin
                     s_d.write_latch_flag = 1'b1;
                  end
               end
               `OP_RSTEN: begin
                  s_d.rst_en = (s_q.bits == `BITS_OP);
               end
               `OP_RST: begin
                  if (s_q.bits == `BITS_OP && s_q.rst_en) begin
                     s_d.crc = `CRC_INIT;
                     s_d.eng = EN_IDLE;
                     s_d.susp = 1'b0;
                     s_d.pend = 1'b0;
                     s_d.abort = 1'b0;
                     s_d.write_latch_flag = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // suspend processing timer
      if (s_q.pend && s_q.pcnt != 16'h0000) begin
         s_d.pcnt = s_q.pcnt - 16'h0001;
      end
      // crc engine, one byte per two cycles
      case (s_q.eng)
         EN_READ: begin
            if (s_q.pend && s_q.pcnt == 16'h0000) begin
               s_d.pend = 1'b0;
               s_d.susp = 1'b1;
               s_d.eng = EN_SUSP;
            end else begin
               s_d.eng = EN_TAKE;
            end
         end
         EN_TAKE: begin
            s_d.grp = word_in;
            s_d.k = s_q.k + 2'd1;
            if (s_q.k == 2'd3 || s_q.addr == s_q.ea) begin
               s_d.crc = crc_nx;
               s_d.grp = 32'h00000000;
            end
            if (s_q.addr == s_q.ea) begin
               s_d.eng = EN_IDLE;
               s_d.pend = 1'b0;
               s_d.write_latch_flag = 1'b0;
            end else begin
               s_d.addr = s_q.addr + 24'h000001;
               s_d.eng = EN_READ;
            end
         end
         EN_SUSP: begin
         end
         default: begin
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.sck_s <= 2'b00;
         s_q.cs_s <= 2'b11;
         s_q.sck_p <= 1'b0;
         s_q.cs_p <= 1'b1;
         s_q.eng <= EN_IDLE;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

/* design/crc_host.sv */
// host controller: ahb-lite registers drive one spi frame per order
`timescale 1ns/1ps
`include "crc_map.svh"
module crc_host #(
   parameter int HALF = `SCK_HALF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   crc_link_if.host link
);
   import crc_pkg::*;

   typedef struct packed {
      logic wr_p;
      logic [7:0] a_p;
      logic [31:0] addr0;
      logic [31:0] addr1;
      logic [31:0] rx;
      logic [31:0] rdata;
      crc_hst_t st;
      logic [55:0] tx;
      logic [6:0] left;
      logic [7:0] div;
      logic [1:0] miso_s;
      logic sck;
      logic cs_n;
   } crc_hst_s_t;

   crc_hst_s_t s_q, s_d;
   logic take, go;
   logic [2:0] naddr, nrx;

   assign take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign link.sck = s_q.sck;
   assign link.cs_n = s_q.cs_n;
   assign link.mosi = s_q.tx[55];
   assign naddr = hwdata[`CTRL_NADDR];
   assign nrx = hwdata[`CTRL_NRX];
   assign go = s_q.wr_p && s_q.a_p == `H_CTRL && s_q.st == HS_IDLE;

   // =======================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.miso_s = {s_q.miso_s[0], link.miso};
      // bus address phase capture and read data
      s_d.wr_p = take & hwrite;
      if (take) begin
         s_d.a_p = haddr[7:0];
         case (haddr[7:0])
            `H_ADDR0: s_d.rdata = s_q.addr0;
            `H_ADDR1: s_d.rdata = s_q.addr1;
            `H_STAT: s_d.rdata = {31'h00000000, s_q.st != HS_IDLE};
            `H_RX: s_d.rdata = s_q.rx;
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // bus data phase writes
      if (s_q.wr_p) begin
         if (s_q.a_p == `H_ADDR0) begin
            s_d.addr0 = hwdata;
         end
         if (s_q.a_p == `H_ADDR1) begin
            s_d.addr1 = hwdata;
         end
      end
      // frame: opcode, start then end address, then read bits
      if (go) begin
         s_d.tx = {hwdata[`CTRL_OP], s_q.addr0[23:0], s_q.addr1[23:0]};
         s_d.left = 7'd8 + {naddr, 3'b000} + {1'b0, nrx, 3'b000};
         s_d.rx = 32'h00000000;
         s_d.cs_n = 1'b0;
         s_d.div = 8'h00;
         s_d.st = HS_LOW;
      end
      case (s_q.st)
         HS_LOW: begin
            s_d.div = s_q.div + 8'h01;
            if (s_q.div == 8'(HALF - 1)) begin
               s_d.div = 8'h00;
               s_d.sck = 1'b1;
               s_d.st = HS_HIGH;
            end
         end
         HS_HIGH: begin
            s_d.div = s_q.div + 8'h01;
            if (s_q.div == 8'(HALF - 1)) begin
               s_d.div = 8'h00;
               s_d.sck = 1'b0;
               s_d.rx = {s_q.rx[30:0], s_q.miso_s[1]};
               s_d.tx = {s_q.tx[54:0], 1'b0};
               s_d.left = s_q.left - 7'd1;
               s_d.st = (s_q.left == 7'd1) ? HS_END : HS_LOW;
            end
         end
         HS_END: begin
            s_d.div = s_q.div + 8'h01;
            if (s_q.div == 8'(HALF - 1)) begin
               s_d.cs_n = 1'b1;
               s_d.st = HS_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.cs_n <= 1'b1;
         s_q.st <= HS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

/* tb/crc_link_checker.sv */
// link and status checker for the range checksum host and device pair
`timescale 1ns/1ps
module crc_link_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic busy,
   input wire logic [31:0] result
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // =====
   // link clock phases, four system cycles each
   sequence sck_hi_s;
      sck [*3] ##1 !sck;
   endsequence
   sequence sck_lo_s;
      !sck [*3];
   endsequence
   // =====
   // framing and data stability
   sck_idle_low_a: assert property (cs_n |-> !sck)
      else $error("link clock active outside frame");
   sck_high_len_a: assert property ($rose(sck) |=> sck_hi_s)
      else $error("link clock high phase wrong");
   sck_low_len_a: assert property ($fell(sck) && !cs_n |=> sck_lo_s)
      else $error("link clock low phase wrong");
   mosi_hold_a: assert property (!cs_n && sck && $past(sck) |-> $stable(mosi))
      else $error("host data moved while clock high");
   miso_hold_a: assert property (!cs_n && sck && $past(sck) |-> $stable(miso))
      else $error("device data moved while clock high");
   // =====
   // engine state against the link
   start_after_cs_a: assert property ($rose(busy) |-> cs_n && $past(cs_n))
      else $error("engine started inside a frame");
   reset_clear_a: assert property ($past(rst) |-> result == 32'h0 && !busy)
      else $error("result or busy not cleared by reset");
   busy_min_a: assert property ($rose(busy) |-> busy [*6])
      else $error("busy dropped too early");
   result_hold_a: assert property (!busy && !$past(busy) && !cs_n && !$past(cs_n)
      |-> $stable(result))
      else $error("result changed while engine idle");
endmodule

/* tb/crc32c_range_engine_tb.sv */
// bench for the range checksum host controller and device pair
`timescale 1ns/1ps
`include "crc_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module crc32c_range_engine_tb;
   logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, mem_rd, busy;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, result, r;
   logic [17:0] mem_addr;
   logic [7:0] mem_rdata, s;
   int errors = 0;
   int total_checks = 0;
   // =====
   // design pair joined by the link
   crc_link_if link ();
   assign hready = hreadyout;
   crc_host u_crc_host (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
   crc_dev #(.SUSP_CYCLES(2)) u_crc_dev (.clk(clk), .rst(rst), .link(link), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .busy(busy), .result(result));
   crc_link_checker u_crc_link_checker (.clk(clk), .rst(rst), .sck(link.sck),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .busy(busy), .result(result));
   // =====
   // array model, one cycle read latency
   function automatic logic [7:0] pat(input logic [17:0] a);
      return a[7:0] ^ {a[11:8], a[3:0]} ^ 8'h5a;
   endfunction
   always @(posedge clk) begin
      if (mem_rd) begin
         mem_rdata <= pat(mem_addr);
      end
   end
   // expected checksum, msb first, zero padded tail group
   function automatic logic [31:0] exp_crc(input logic [17:0] sa, input logic [17:0] ea);
      logic [31:0] c, w;
      c = 32'h0;
      for (int a = int'(sa); a <= int'(ea); a += 4) begin
         w = 32'h0;
         for (int k = 0; k < 4; k++) begin
            if (a + k <= int'(ea)) begin
               w[31-8*k -: 8] = pat(18'(a + k));
            end
         end
         c = c ^ w;
         for (int k = 0; k < 32; k++) begin
            c = c[31] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
         end
      end
      return c;
   endfunction
   // =====
   // bus and frame tasks
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic frame(input logic [7:0] op, input logic [2:0] na, input logic [2:0] nr,
         input logic [23:0] a0, input logic [23:0] a1);
      ahb(1'b1, `H_ADDR0, {8'h0, a0});
      ahb(1'b1, `H_ADDR1, {8'h0, a1});
      ahb(1'b1, `H_CTRL, {17'h0, nr, 1'b0, na, op});
      r = 32'h1;
      for (int i = 0; i < 400 && r[0] !== 1'b0; i++) begin
         ahb(1'b0, `H_STAT, 32'h0);
      end
      // a frame that never ends counts as a mismatch
      if (r[0] !== 1'b0) begin
         errors++;
      end
      repeat (8) @(posedge clk);
      ahb(1'b0, `H_RX, 32'h0);
   endtask
   task automatic st(input logic [7:0] op);
      frame(op, 3'd0, 3'd1, 24'h0, 24'h0);
      s = r[7:0];
   endtask
   task automatic wait_idle;
      s = 8'h1;
      for (int i = 0; i < 100 && s[0] !== 1'b0; i++) begin
         st(`OP_RDSR1);
      end
      // a work flag that never drops counts as a mismatch
      if (s[0] !== 1'b0) begin
         errors++;
      end
   endtask
   task automatic calc(input logic [23:0] sa, input logic [23:0] ea);
      frame(`OP_START, 3'd6, 3'd0, sa, ea);
      wait_idle;
      frame(`OP_READ_ANY_REGISTER_CMD, 3'd3, 3'd4, `RESULT_RADDR, 24'h0);
      `CHK("crc", exp_crc(sa[17:0], ea[17:0]), r)
   endtask
   // =====
   // scenarios
   task automatic t_reset;
      `CHK("result port", 32'h0, result)
      frame(`OP_READ_ANY_REGISTER_CMD, 3'd3, 3'd4, `RESULT_RADDR, 24'h0);
      `CHK("result read", 32'h0, r)
      `CHK("hresp", 1'b0, hresp)
   endtask
   task automatic t_calc;
      calc(24'h10, 24'h17);
      calc(24'h20, 24'h25);
      calc(24'h3, 24'h6);
   endtask
   task automatic t_trunc;
      frame(`OP_START, 3'd5, 3'd0, 24'h10, 24'h13);
      `CHK("busy short", 1'b0, busy)
      `CHK("result kept", exp_crc(18'h3, 18'h6), result)
   endtask
   task automatic t_wel;
      frame(`OP_WREN, 3'd0, 3'd0, 24'h0, 24'h0);
      st(`OP_RDSR1);
      `CHK("latch set", 1'b1, s[1])
      calc(24'h10, 24'h13);
      st(`OP_RDSR1);
      `CHK("latch clear", 8'h00, s)
   endtask
   task automatic t_abort;
      frame(`OP_START, 3'd6, 3'd0, 24'h40, 24'h42);
      st(`OP_RDSR2);
      `CHK("abort flag", 1'b1, s[3])
      `CHK("abort busy", 1'b0, busy)
   endtask
   task automatic t_susp;
      logic [17:0] sa;
      frame(`OP_START, 3'd6, 3'd0, 24'h0, 24'h3ff);
      st(`OP_RDSR1);
      `CHK("work flag", 1'b1, s[0])
      frame(`OP_SUSP, 3'd0, 3'd0, 24'h0, 24'h0);
      wait_idle;
      st(`OP_RDSR2);
      `CHK("susp flag", 1'b1, s[4])
      frame(`OP_READ_ANY_REGISTER_CMD, 3'd3, 3'd4, `RESULT_RADDR, 24'h0);
      // held crc covers every whole group below the parked address
      sa = {mem_addr[17:2], 2'b00};
      `CHK("susp read", (sa == 18'h0) ? 32'h0 : exp_crc(18'h0, sa - 18'h1), r)
      frame(`OP_WREN, 3'd0, 3'd0, 24'h0, 24'h0);
      st(`OP_RDSR1);
      `CHK("susp wren", 8'h00, s)
      frame(`OP_RESUME, 3'd0, 3'd0, 24'h0, 24'h0);
      wait_idle;
      st(`OP_RDSR2);
      `CHK("done flag", 1'b0, s[4])
      frame(`OP_READ_ANY_REGISTER_CMD, 3'd3, 3'd4, `RESULT_RADDR, 24'h0);
      `CHK("resumed crc", exp_crc(18'h0, 18'h3ff), r)
   endtask
   task automatic t_idle;
      frame(`OP_SUSP, 3'd0, 3'd0, 24'h0, 24'h0);
      st(`OP_RDSR2);
      `CHK("idle susp", 1'b0, s[4])
      frame(`OP_RESUME, 3'd0, 3'd0, 24'h0, 24'h0);
      `CHK("idle resume", 1'b0, busy)
   endtask
   // software reset while suspended clears flags and result
   task automatic t_rst;
      frame(`OP_START, 3'd6, 3'd0, 24'h0, 24'h3ff);
      frame(`OP_SUSP, 3'd0, 3'd0, 24'h0, 24'h0);
      wait_idle;
      frame(`OP_RSTEN, 3'd0, 3'd0, 24'h0, 24'h0);
      frame(`OP_RST, 3'd0, 3'd0, 24'h0, 24'h0);
      st(`OP_RDSR2);
      `CHK("rst status", 8'h00, s)
      `CHK("rst result", 32'h0, result)
   endtask
   // =====
   // verdict, clock, watchdog and main sequence
   task automatic test_done;
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #300000;
      errors++;
      test_done;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      mem_rdata = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset;
      t_calc;
      t_trunc;
      t_wel;
      t_abort;
      t_susp;
      t_idle;
      t_rst;
      test_done;
   end
endmodule
